/* rtl/lpd_pkg.sv */
// constants, register indices and reset values for the led dimmer block
// assumes a 125 MHz system clock; used by the top and the serial receiver
package lpd_pkg;
  // timing
  localparam int ACLK_HZ    = 125_000_000;
  localparam int OSC_HZ     = 25_000_000;
  localparam int OSC_DIV    = ACLK_HZ / OSC_HZ;
  localparam int PWM_STEPS  = 256;
  localparam int BLINK_HZ   = 24;
  localparam int BLINK_STEP = OSC_HZ / (BLINK_HZ * PWM_STEPS);
  localparam int FILT_LEN   = 3;
  // sizes
  localparam int NLED       = 24;
  localparam int NREG       = 39;
  localparam int N_STATE_RG = 6;
  localparam int AXI_AW     = 8;
  // serial framing
  localparam logic [3:0] LAST_BIT       = 4'h7;
  localparam logic [3:0] ACK_BIT        = 4'h8;
  localparam logic [7:0] BUS_RESET_ADDR = 8'h06;
  localparam logic       ADDR_HI        = 1'h0;
  localparam int         CTL_AIF        = 7;
  // register indices
  localparam logic [5:0] IDX_MODE_A      = 6'h00;
  localparam logic [5:0] IDX_MODE_B      = 6'h01;
  localparam logic [5:0] IDX_DUTY0       = 6'h02;
  localparam logic [5:0] IDX_GROUP_DUTY  = 6'h1A;
  localparam logic [5:0] IDX_GROUP_RATE  = 6'h1B;
  localparam logic [5:0] IDX_LED_STATE0  = 6'h1C;
  localparam logic [5:0] IDX_SUB_CALL_1  = 6'h22;
  localparam logic [5:0] IDX_SUB_CALL_2  = 6'h23;
  localparam logic [5:0] IDX_SUB_CALL_3  = 6'h24;
  localparam logic [5:0] IDX_GROUP_CALL  = 6'h25;
  localparam logic [5:0] IDX_CHASE       = 6'h26;
  localparam logic [5:0] IDX_STATUS      = 6'h27;
  localparam logic [5:0] IDX_LAST        = 6'h26;
  // field positions
  localparam int MA_GROUP_CALL_EN = 0;
  localparam int MA_SUB3_EN       = 1;
  localparam int MA_SUB2_EN       = 2;
  localparam int MA_SUB1_EN       = 3;
  localparam int MB_CHANGE_ON_ACK = 3;
  localparam int MB_BLINK         = 5;
  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_MODE_A     = 8'h01;
  localparam logic [7:0] RST_GROUP_DUTY = 8'hFF;
  localparam logic [7:0] RST_SUB_1      = 8'hE2;
  localparam logic [7:0] RST_SUB_2      = 8'hE4;
  localparam logic [7:0] RST_SUB_3      = 8'hE8;
  localparam logic [7:0] RST_GROUP_CALL = 8'hE0;
  localparam logic [7:0] CHASE_ALL      = 8'h00;
  // led state codes
  localparam logic [1:0] LS_OFF  = 2'h0;
  localparam logic [1:0] LS_ON   = 2'h1;
  localparam logic [1:0] LS_IND  = 2'h2;
  localparam logic [1:0] LS_BOTH = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FR_IDLE, FR_CTRL, FR_DATA, FR_SKIP}
    lpd_frame_type;

  function automatic logic [7:0] lpd_reset_value(input logic [5:0] idx);
    case (idx)
      IDX_MODE_A:     return RST_MODE_A;
      IDX_GROUP_DUTY: return RST_GROUP_DUTY;
      IDX_SUB_CALL_1: return RST_SUB_1;
      IDX_SUB_CALL_2: return RST_SUB_2;
      IDX_SUB_CALL_3: return RST_SUB_3;
      IDX_GROUP_CALL: return RST_GROUP_CALL;
      default:        return RST_ZERO;
    endcase
  endfunction : lpd_reset_value
endpackage : lpd_pkg

/* rtl/lpd_serial_rx.sv */
// write-only two-wire serial receiver: sync, filter, start/stop, bytes
// assumes pins are asynchronous to aclk; the master drives every bit
`timescale 1ns/1ns
module lpd_serial_rx
  import lpd_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // pins
  input  wire logic       bus_clk_pin,
  input  wire logic       bus_data_pin,
  // decoded events
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            byte_first,
  output logic            ack_tick,
  output logic            stop_tick,
  output logic            bus_busy
);
  logic [1:0]          scl_sync;
  logic [1:0]          sda_sync;
  logic [FILT_LEN-1:0] scl_hist;
  logic [FILT_LEN-1:0] sda_hist;
  logic                scl_f;
  logic                sda_f;
  logic                scl_d;
  logic                sda_d;
  logic [3:0]          bit_cnt;
  logic [6:0]          shift;
  logic                first_pend;
  logic                scl_rise;
  logic                start_ev;
  logic                stop_ev;

  // two-stage synchronisers, then a spike filter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_hist <= '1;
      sda_hist <= '1;
    end else begin
      scl_sync <= {scl_sync[0], bus_clk_pin};
      sda_sync <= {sda_sync[0], bus_data_pin};
      scl_hist <= {scl_hist[FILT_LEN-2:0], scl_sync[1]};
      sda_hist <= {sda_hist[FILT_LEN-2:0], sda_sync[1]};
    end
  end

  // a level is taken only after it stands for the whole history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_f <= 1'h1;
      sda_f <= 1'h1;
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      if (&scl_hist) scl_f <= 1'h1;
      else if (~|scl_hist) scl_f <= 1'h0;
      if (&sda_hist) sda_f <= 1'h1;
      else if (~|sda_hist) sda_f <= 1'h0;
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d;
  assign start_ev = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_ev  = scl_f & scl_d & ~sda_d & sda_f;

  // bit counter: eight data bits, then the master-driven ninth bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_valid <= 1'h0;
      byte_data  <= 8'h00;
      byte_first <= 1'h0;
      ack_tick   <= 1'h0;
      stop_tick  <= 1'h0;
      bus_busy   <= 1'h0;
      bit_cnt    <= 4'h0;
      shift      <= 7'h00;
      first_pend <= 1'h0;
    end else begin
      byte_valid <= 1'h0;
      ack_tick   <= 1'h0;
      stop_tick  <= stop_ev;
      if (start_ev) begin
        bit_cnt    <= 4'h0;
        first_pend <= 1'h1;
        bus_busy   <= 1'h1;
      end else if (stop_ev) begin
        bit_cnt  <= 4'h0;
        bus_busy <= 1'h0;
      end else if (scl_rise && bus_busy) begin
        if (bit_cnt == ACK_BIT) begin
          bit_cnt  <= 4'h0;
          ack_tick <= 1'h1;
        end else begin
          shift   <= {shift[5:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == LAST_BIT) begin
            byte_valid <= 1'h1;
            byte_data  <= {shift, sda_f};
            byte_first <= first_pend;
            first_pend <= 1'h0;
          end
        end
      end
    end
  end
endmodule : lpd_serial_rx

/* rtl/lpd_top.sv */
// led dimmer/blinker core: 24 pwm outputs, serial slave, axi4-lite regs
// assumes serial pins and gate pin are asynchronous; aclk is 125 MHz
//
// What this block does
// - each led has own 8-bit ~97 kHz pwm
// - shared group pwm: dim ~190 Hz or blink
// - per-led state: off, on, pwm, pwm+group
// - active-low gate pin turns all outputs off
// - reset call restores every register default
// - pattern byte forces unselected outputs off
// - states take effect at ack or stop
// - six address pins form the slave address
// - group and three sub addresses, each enableable
// - serial link is write-only, device never drives
// - timing from a 25 MHz tick enable
// - led duties reset to off, linear steps
// - group duty resets to maximum
// - outputs stay off through reset
// - spike filter on serial clock and data
// - control byte: pointer, auto-increment, spare bit
// - group call default enabled, reset call address
// - reset call ignored with read bit set
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module lpd_top
  import lpd_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // serial pins
  input  wire logic              bus_clk_pin,
  input  wire logic              bus_data_pin,
  // straps and gate
  input  wire logic [5:0]        hw_addr_pin,
  input  wire logic              out_enable_n_pin,
  // led sinks, high sinks current
  output logic [NLED-1:0]        led_sink_out
);
  logic [7:0]    regs [0:NREG-1];
  logic [7:0]    led_live [0:N_STATE_RG-1];
  logic [1:0]    addr_sync [0:5];
  logic [5:0]    hw_addr_s;
  logic [1:0]    oe_sync;
  logic          oe_n_s;
  logic          ser_valid;
  logic [7:0]    ser_byte;
  logic          ser_first;
  logic          ser_ack;
  logic          ser_stop;
  logic          ser_busy;
  lpd_frame_type frame;
  logic [5:0]    ptr;
  logic          pointer_autoinc_flag;
  logic          soft_rst;
  logic          match;
  logic          ser_wr;
  logic [5:0]    aw_idx;
  logic [7:0]    w_byte;
  logic          w_lane;
  logic          axi_do;
  logic          axi_wr;
  logic          axi_commit;
  logic          commit;
  logic [5:0]    ar_idx;
  logic [2:0]    osc_cnt;
  logic          osc_tick;
  logic [7:0]    ind_cnt;
  logic          dim_half;
  logic [11:0]   pre_cnt;
  logic [7:0]    rate_cnt;
  logic [7:0]    grp_cnt;
  logic          grp_step;
  logic          grp_on;
  logic [7:0]    mode_a;
  logic [7:0]    mode_b;

  assign mode_a = regs[IDX_MODE_A];
  assign mode_b = regs[IDX_MODE_B];

  // pin synchronisers
  for (genvar a = 0; a < 6; a++) begin : g_addr
    always_ff @(posedge aclk) begin
      if (!aresetn) addr_sync[a] <= 2'h0;
      else addr_sync[a] <= {addr_sync[a][0], hw_addr_pin[a]};
    end
    assign hw_addr_s[a] = addr_sync[a][1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) oe_sync <= 2'h3;
    else oe_sync <= {oe_sync[0], out_enable_n_pin};
  end
  assign oe_n_s = oe_sync[1];

  // receive only: the data pin is never driven
  lpd_serial_rx u_rx (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .bus_clk_pin  (bus_clk_pin),
    .bus_data_pin (bus_data_pin),
    .byte_valid   (ser_valid),
    .byte_data    (ser_byte),
    .byte_first   (ser_first),
    .ack_tick     (ser_ack),
    .stop_tick    (ser_stop),
    .bus_busy     (ser_busy)
  );

  // address match against straps and enabled call addresses
  always_comb begin
    match = (ser_byte[7:1] == {ADDR_HI, hw_addr_s});
    if (mode_a[MA_GROUP_CALL_EN] &&
        ser_byte[7:1] == regs[IDX_GROUP_CALL][7:1]) match = 1'h1;
    if (mode_a[MA_SUB1_EN] &&
        ser_byte[7:1] == regs[IDX_SUB_CALL_1][7:1]) match = 1'h1;
    if (mode_a[MA_SUB2_EN] &&
        ser_byte[7:1] == regs[IDX_SUB_CALL_2][7:1]) match = 1'h1;
    if (mode_a[MA_SUB3_EN] &&
        ser_byte[7:1] == regs[IDX_SUB_CALL_3][7:1]) match = 1'h1;
  end

  // reset call: full byte compare keeps the direction bit at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) soft_rst <= 1'h0;
    else soft_rst <= ser_valid && ser_first &&
                     ser_byte == BUS_RESET_ADDR;
  end

  // frame sequencing: address, control byte, data bytes
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      frame <= FR_IDLE;
      ptr   <= 6'h00;
      pointer_autoinc_flag   <= 1'h0;
    end else if (ser_stop) begin
      frame <= FR_IDLE;
    end else if (ser_valid && ser_first) begin
      frame <= (match && !ser_byte[0]) ? FR_CTRL : FR_SKIP;
    end else if (ser_valid) begin
      case (frame)
        FR_CTRL: begin
          ptr   <= ser_byte[5:0];
          pointer_autoinc_flag   <= ser_byte[CTL_AIF];
          frame <= FR_DATA;
        end
        FR_DATA: begin
          if (pointer_autoinc_flag) ptr <= (ptr == IDX_LAST) ? 6'h00 : ptr + 6'h01;
        end
        default: frame <= frame;
      endcase
    end
  end

  assign ser_wr = ser_valid && !ser_first && frame == FR_DATA &&
                  ptr <= IDX_LAST;

  // axi write channels; serial writes take precedence
  assign axi_do = !awready && !wready && !bvalid && !ser_wr;
  assign axi_wr = axi_do && w_lane && aw_idx <= IDX_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'h1;
      aw_idx  <= 6'h00;
    end else if (awvalid && awready) begin
      awready <= 1'h0;
      aw_idx  <= awaddr[AXI_AW-1:2];
    end else if (axi_do) begin
      awready <= 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'h1;
      w_byte <= 8'h00;
      w_lane <= 1'h0;
    end else if (wvalid && wready) begin
      wready <= 1'h0;
      w_byte <= wdata[7:0];
      w_lane <= wstrb[0];
    end else if (axi_do) begin
      wready <= 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'h0;
      bresp  <= RESP_OKAY;
    end else if (axi_do) begin
      bvalid <= 1'h1;
      bresp  <= (aw_idx <= IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'h0;
    end
  end

  // axi read: registers, status byte, error beyond the map
  assign ar_idx = araddr[AXI_AW-1:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'h1;
      rvalid  <= 1'h0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'h0;
      rvalid  <= 1'h1;
      rresp   <= RESP_OKAY;
      if (ar_idx <= IDX_LAST) rdata <= {24'h000000, regs[ar_idx]};
      else if (ar_idx == IDX_STATUS)
        rdata <= {24'h000000, ser_busy, oe_n_s, hw_addr_s};
      else begin
        rdata <= 32'h0000_0000;
        rresp <= RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'h0;
      arready <= 1'h1;
    end
  end

  // register file; reset call returns every entry to its default
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst)
        regs[g] <= lpd_reset_value(6'(g));
      else if (ser_wr && ptr == 6'(g)) regs[g] <= ser_byte;
      else if (axi_wr && aw_idx == 6'(g)) regs[g] <= w_byte;
    end
  end

  // output states go live at ack or stop, axi writes next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) axi_commit <= 1'h0;
    else axi_commit <= axi_do;
  end

  assign commit = axi_commit || (mode_b[MB_CHANGE_ON_ACK] ?
                  (ser_ack && frame == FR_DATA) : ser_stop);

  for (genvar s = 0; s < N_STATE_RG; s++) begin : g_live
    always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) led_live[s] <= RST_ZERO;
      else if (commit)
        led_live[s] <= regs[int'(IDX_LED_STATE0) + s];
    end
  end

  // 25 MHz tick and free-running individual counter
  assign osc_tick = (osc_cnt == 3'(OSC_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt <= 3'h0;
      ind_cnt <= 8'h00;
    end else begin
      osc_cnt <= osc_tick ? 3'h0 : osc_cnt + 3'h1;
      if (osc_tick) ind_cnt <= ind_cnt + 8'h01;
    end
  end

  // group step: every second individual wrap, or blink prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dim_half <= 1'h0;
      pre_cnt  <= 12'h000;
      rate_cnt <= 8'h00;
      grp_step <= 1'h0;
    end else begin
      grp_step <= 1'h0;
      if (osc_tick && ind_cnt == 8'hFF) begin
        dim_half <= ~dim_half;
        if (!mode_b[MB_BLINK] && dim_half) grp_step <= 1'h1;
      end
      if (osc_tick) begin
        if (pre_cnt == 12'(BLINK_STEP - 1)) begin
          pre_cnt <= 12'h000;
          if (rate_cnt >= regs[IDX_GROUP_RATE]) begin
            rate_cnt <= 8'h00;
            if (mode_b[MB_BLINK]) grp_step <= 1'h1;
          end else begin
            rate_cnt <= rate_cnt + 8'h01;
          end
        end else begin
          pre_cnt <= pre_cnt + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) grp_cnt <= 8'h00;
    else if (grp_step) grp_cnt <= grp_cnt + 8'h01;
  end

  assign grp_on = grp_cnt < regs[IDX_GROUP_DUTY];

  // pattern byte: zero enables all, n enables only output n-1
  function automatic logic chase_en(input logic [7:0] pat,
                                    input int idx);
    if (pat == CHASE_ALL) return 1'h1;
    return pat == 8'(idx + 1);
  endfunction : chase_en

  // per-output state select and final gating
  for (genvar i = 0; i < NLED; i++) begin : g_led
    logic [1:0] st;
    logic       ind_on;
    logic       drive;
    assign st     = led_live[i / 4][2 * (i % 4) +: 2];
    assign ind_on = ind_cnt < regs[int'(IDX_DUTY0) + i];

    always_comb begin
      case (st)
        LS_OFF:  drive = 1'h0;
        LS_ON:   drive = 1'h1;
        LS_IND:  drive = ind_on;
        LS_BOTH: drive = ind_on & grp_on;
        default: drive = 1'h0;
      endcase
    end

    always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) led_sink_out[i] <= 1'h0;
      else led_sink_out[i] <= drive & ~oe_n_s &
                              chase_en(regs[IDX_CHASE], i);
    end
  end
endmodule : lpd_top

/* verification/lpd_top_asserts.sv */
// checker: axi read and response relations, led reset and gate
// assumes one aclk domain with a synchronous active-low reset
`timescale 1ns/1ns
module lpd_chk
  import lpd_pkg::*;
(
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // axi4-lite
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  // gate and leds
  input wire logic              out_enable_n_pin,
  input wire logic [NLED-1:0]   led_sink_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_dark; disable iff (1'b0) !aresetn |=> led_sink_out == '0;
  endproperty
  a_rst_dark: assert property (p_rst_dark) else $error("lit in reset");
  property p_gate_off; out_enable_n_pin [*5] |-> led_sink_out == '0;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate ignored");
  property p_rd_err; arvalid && arready && araddr[7:2] > 6'h27 |=>
    rvalid && rresp == RESP_SLVERR && rdata == 32'h0; endproperty
  a_rd_err: assert property (p_rd_err) else $error("bad read err");
  property p_rd_ans; arvalid && arready |=> rvalid && !arready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read late");
  property p_rd_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read moved");
  property p_rd_byte; rvalid |-> rdata[31:8] == 24'h0; endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("upper bits");
  property p_wr_hold; bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("resp moved");
  property p_rd_drop; rvalid && rready |=> !rvalid && arready; endproperty
  a_rd_drop: assert property (p_rd_drop) else $error("read stuck");
  c_gate: cover property (out_enable_n_pin [*5]);
  c_rd_err: cover property (rvalid && rresp == RESP_SLVERR);
  c_led_on: cover property (led_sink_out != '0);
endmodule : lpd_chk
bind lpd_top lpd_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .out_enable_n_pin(out_enable_n_pin),
  .led_sink_out(led_sink_out));

/* verification/lpd_bus_master.sv */
// write-only serial bus master model, msb first, 80 ns bits
// assumes pulled-up lines: both idle high, clock still between frames
`timescale 1ns/1ns
module lpd_bus_master (
  // serial pins
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic begin_frame;
    sda = 1'b0;
    #40;
    scl = 1'b0;
  endtask : begin_frame
  // g adds a 6 ns clock spike inside the low phase
  task automatic put_bit(input logic b, input logic g);
    #10;
    sda = b;
    #15;
    if (g) begin
      scl = 1'b1;
      #6;
      scl = 1'b0;
    end
    #15;
    scl = 1'b1;
    #40;
    scl = 1'b0;
  endtask : put_bit
  task automatic put_byte(input logic [7:0] b, input logic g);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], g && i == 4);
    end
    put_bit(1'b1, 1'b0);
  endtask : put_byte
  task automatic end_frame;
    #10;
    sda = 1'b0;
    #30;
    scl = 1'b1;
    #40;
    sda = 1'b1;
    #80;
  endtask : end_frame
endmodule : lpd_bus_master

/* verification/tb_top.sv */
// self-checking bench for lpd_top: axi registers, serial frames, leds
// assumes lpd_bus_master drives the serial pins out of phase with aclk
`timescale 1ns/1ns
module tb_top
  import lpd_pkg::*;
;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, bad;
  logic              scl, sda, out_enable_n_pin;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [5:0]        hw_addr_pin;
  logic [7:0]        my_addr, rnd;
  logic [NLED-1:0]   led_sink_out;
  logic [33:0]       exp_rd[$];
  logic [1:0]        exp_wr[$];
  int                error_cnt, total_checks, seed, hi_cnt;
  lpd_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bus_clk_pin(scl), .bus_data_pin(sda),
    .hw_addr_pin(hw_addr_pin), .out_enable_n_pin(out_enable_n_pin),
    .led_sink_out(led_sink_out));
  lpd_bus_master bm_u (.scl(scl), .sda(sda));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end
  // result watcher: oldest note against each response
  always @(posedge aclk) begin
    if (rvalid && rready) check({rresp, rdata}, exp_rd.pop_front());
    if (bvalid && bready) check(34'(bresp), 34'(exp_wr.pop_front()));
  end
  task automatic axi(input logic wr, input logic [5:0] i,
                     input logic [7:0] d, input logic [1:0] r);
    logic [31:0] t;
    t = $random(seed);
    @(posedge aclk);
    if (wr) begin
      exp_wr.push_back(r);
      {awaddr, awvalid, wvalid, bready} <= {i, 2'h0, 3'h7};
      wdata <= {t[31:8], d};
    end else begin
      exp_rd.push_back({r, 24'h0, d});
      {araddr, arvalid, rready} <= {i, 2'h0, 2'h3};
    end
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(wr ? bvalid : rvalid));
    {bready, rready} <= 2'h0;
  endtask : axi
  task automatic led_chk(input logic [23:0] e);
    repeat (8) @(posedge aclk);
    check({10'h0, led_sink_out}, {10'h0, e});
  endtask : led_chk
  task automatic sframe(input logic [7:0] a, input logic [7:0] c,
                        input logic [7:0] d);
    bm_u.begin_frame();
    bm_u.put_byte(a, 1'b0);
    bm_u.put_byte(c, 1'b0);
    bm_u.put_byte(d, 1'b0);
  endtask : sframe
  initial begin
    seed = 22074;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    out_enable_n_pin = 1'b0;
    hw_addr_pin = 6'h20 | 6'($random(seed));
    my_addr = {1'b0, hw_addr_pin, 1'b0};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    check({10'h0, led_sink_out}, 34'h0);
    axi(1'b0, IDX_MODE_A, RST_MODE_A, RESP_OKAY);
    axi(1'b0, IDX_GROUP_CALL, RST_GROUP_CALL, RESP_OKAY);
    axi(1'b0, IDX_GROUP_DUTY, RST_GROUP_DUTY, RESP_OKAY);
    axi(1'b0, IDX_DUTY0 + 6'h7, RST_ZERO, RESP_OKAY);
    axi(1'b0, IDX_STATUS, {2'h0, hw_addr_pin}, RESP_OKAY);
    axi(1'b0, 6'h30, RST_ZERO, RESP_SLVERR);
    axi(1'b1, 6'h30, 8'h12, RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      rnd = 8'($random(seed));
      axi(1'b1, IDX_DUTY0 + 6'(k), rnd, RESP_OKAY);
      axi(1'b0, IDX_DUTY0 + 6'(k), rnd, RESP_OKAY);
    end
    axi(1'b1, IDX_LED_STATE0, 8'h55, RESP_OKAY);
    led_chk(24'h00000F);
    axi(1'b1, IDX_CHASE, 8'h02, RESP_OKAY);
    led_chk(24'h000002);
    axi(1'b1, IDX_CHASE, 8'hFF, RESP_OKAY);
    led_chk(24'h000000);
    axi(1'b1, IDX_CHASE, CHASE_ALL, RESP_OKAY);
    out_enable_n_pin <= 1'b1;
    led_chk(24'h000000);
    out_enable_n_pin <= 1'b0;
    led_chk(24'h00000F);
    axi(1'b1, IDX_DUTY0 + 6'h2, 8'h80, RESP_OKAY);
    axi(1'b1, IDX_DUTY0 + 6'h3, RST_ZERO, RESP_OKAY);
    axi(1'b1, IDX_LED_STATE0, 8'hE4, RESP_OKAY);
    repeat (8) @(posedge aclk);
    {hi_cnt, bad} = 0;
    repeat (1280) begin
      @(posedge aclk);
      hi_cnt += led_sink_out[2];
      bad |= led_sink_out[3] | led_sink_out[0] | !led_sink_out[1];
    end
    check(34'(hi_cnt), 34'h280);
    check(34'(bad), 34'h0);
    axi(1'b1, IDX_DUTY0 + 6'h2, 8'hFF, RESP_OKAY);
    axi(1'b1, IDX_GROUP_DUTY, RST_ZERO, RESP_OKAY);
    axi(1'b1, IDX_LED_STATE0, 8'hF4, RESP_OKAY);
    led_chk(24'h000002);
    axi(1'b1, IDX_GROUP_DUTY, RST_GROUP_DUTY, RESP_OKAY);
    axi(1'b1, IDX_LED_STATE0, RST_ZERO, RESP_OKAY);
    bm_u.begin_frame();
    bm_u.put_byte(my_addr, 1'b0);
    bm_u.put_byte(8'h9D, 1'b0);
    bm_u.put_byte(8'h55, 1'b1);
    bm_u.put_byte(8'hAA, 1'b0);
    led_chk(24'h000000);
    bm_u.end_frame();
    led_chk(24'h0000F0);
    axi(1'b0, IDX_LED_STATE0 + 6'h2, 8'hAA, RESP_OKAY);
    axi(1'b1, IDX_MODE_B, 8'h08, RESP_OKAY);
    sframe(my_addr, 8'h1F, 8'h55);
    led_chk(24'h00F0F0);
    bm_u.end_frame();
    axi(1'b1, IDX_MODE_B, RST_ZERO, RESP_OKAY);
    sframe(RST_GROUP_CALL, 8'h20, 8'h55);
    bm_u.end_frame();
    led_chk(24'h0FF0F0);
    axi(1'b1, IDX_MODE_A, RST_ZERO, RESP_OKAY);
    sframe(RST_GROUP_CALL, 8'h21, 8'h55);
    bm_u.end_frame();
    led_chk(24'h0FF0F0);
    axi(1'b1, IDX_MODE_A, 8'h08, RESP_OKAY);
    sframe(RST_SUB_1, 8'h21, 8'h55);
    bm_u.end_frame();
    led_chk(24'hFFF0F0);
    bm_u.begin_frame();
    bm_u.put_byte(BUS_RESET_ADDR | 8'h01, 1'b0);
    bm_u.end_frame();
    led_chk(24'hFFF0F0);
    bm_u.begin_frame();
    bm_u.put_byte(BUS_RESET_ADDR, 1'b0);
    bm_u.end_frame();
    led_chk(24'h000000);
    axi(1'b0, IDX_MODE_A, RST_MODE_A, RESP_OKAY);
    axi(1'b0, IDX_LED_STATE0 + 6'h5, RST_ZERO, RESP_OKAY);
    finish_test();
  end
endmodule : tb_top
